// ### bench/tmc_far_side.sv
// Purpose: Far-side model driving the count pin, trigger pin and other-timer overflow.
// Assumes: Both pins have pull-ups, so they idle high.
// Notes: Each pin phase lasts four clocks, above the two-clock minimum.
module tmc_far_side (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic t1_en_i,
  output logic count_pin_o,
  output logic trigger_pin_o,
  output logic t1_overflow_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int pulses = 0;
  logic [2:0] div = 3'h0;
  initial begin
    count_pin_o = 1'b1;
    trigger_pin_o = 1'b1;
    t1_overflow_o = 1'b0;
  end
  // One overflow pulse every eight clocks while enabled.
  always @(posedge mclk_i) begin
    div <= div + 3'h1;
    t1_overflow_o <= t1_en_i && !rst_i && div == 3'h7;
    if (t1_overflow_o === 1'b1) pulses++;
  end
  task automatic drop(input bit trig);
    repeat (4) @(posedge mclk_i);
    if (trig) trigger_pin_o <= 1'b0;
    else count_pin_o <= 1'b0;
    repeat (4) @(posedge mclk_i);
    trigger_pin_o <= 1'b1;
    count_pin_o <= 1'b1;
  endtask
endmodule

// ### bench/tmc_top_tb.sv
// Purpose: Self-checking bench for the third-timer control block.
// Assumes: Register write and read go through single classic Wishbone cycles.
// Notes: The step-count range check allows one step of slack for bus latency; the count reads themselves are exact.
module tmc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] q;
  logic [1:0] serial_mode_i = 2'h1;
  logic ack_o, count_pin, trigger_pin, t1_ovf, rx_tick, tx_tick, timer_req_o, irq_o;
  logic t1_en = 1'b0;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int rx_n = 0;
  int tx_n = 0;
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  tmc_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .count_pin_i(count_pin),
    .trigger_pin_i(trigger_pin), .serial_mode_i(serial_mode_i), .t1_overflow_i(t1_ovf),
    .rx_baud_tick_o(rx_tick), .tx_baud_tick_o(tx_tick), .timer_req_o(timer_req_o), .irq_o(irq_o));
  tmc_far_side far (.mclk_i(mclk_i), .rst_i(rst_i), .t1_en_i(t1_en), .count_pin_o(count_pin),
    .trigger_pin_o(trigger_pin), .t1_overflow_o(t1_ovf));
  task automatic conclude();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (rx_tick === 1'b1) rx_n++;
    if (tx_tick === 1'b1) tx_n++;
    if (cycles == 30000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // Request is held until ack is sampled high, then released for at least one cycle.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    do @(posedge mclk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    sel_i <= 4'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  initial begin
    idle(20);
    rst_i <= 1'b0;
    idle(1);
    rd(tmc_pkg::OFF_CTRL, 32'h0, "control reset");
    rd(8'he0, 32'h0, "unmapped read");
    $display("test reset done");
    for (int m = 0; m < 2; m++) begin
      wb(1'b1, tmc_pkg::OFF_MODE, 32'(m * 2));
      wb(1'b1, tmc_pkg::OFF_COUNT, 32'h0);
      wb(1'b1, tmc_pkg::OFF_CTRL, 32'h04);
      idle(120);
      wb(1'b1, tmc_pkg::OFF_CTRL, 32'h00);
      rd(tmc_pkg::OFF_COUNT, 32'(10 * m + 10), "count after run");
      chk("step count in range", 32'h1, 32'(q >= 32'(10 * m + 9) && q <= 32'(10 * m + 11)));
      idle(30);
      rd(tmc_pkg::OFF_COUNT, q, "count held");
    end
    $display("test prescaler done");
    wb(1'b1, tmc_pkg::OFF_COUNT, 32'hfffe);
    wb(1'b1, tmc_pkg::OFF_CTRL, 32'h04);
    idle(30);
    rd(tmc_pkg::OFF_CTRL, 32'h84, "overflow flag set");
    idle(20);
    rd(tmc_pkg::OFF_CTRL, 32'h84, "overflow flag sticky");
    wb(1'b1, tmc_pkg::OFF_CTRL, 32'h00);
    rd(tmc_pkg::OFF_CTRL, 32'h0, "overflow flag cleared");
    rd(tmc_pkg::OFF_IRQ_STAT, 32'h1, "status overflow");
    chk("irq masked", 32'h0, 32'(irq_o));
    wb(1'b1, tmc_pkg::OFF_IRQ_MASK, 32'h1);
    idle(3);
    chk("irq unmasked", 32'h1, 32'(irq_o));
    wb(1'b1, tmc_pkg::OFF_IRQ_STAT, 32'h1);
    idle(3);
    chk("irq after clear", 32'h0, 32'(irq_o));
    $display("test overflow done");
    for (int m = 0; m < 4; m++) begin
      serial_mode_i <= 2'(m);
      wb(1'b1, tmc_pkg::OFF_COUNT, 32'hfffe);
      rx_n = 0;
      tx_n = 0;
      wb(1'b1, tmc_pkg::OFF_CTRL, 32'h34);
      idle(30);
      rd(tmc_pkg::OFF_CTRL, 32'h34, "no overflow flag as baud source");
      wb(1'b1, tmc_pkg::OFF_CTRL, 32'h00);
      chk("rx ticks from this timer", 32'(m % 2), 32'(rx_n));
      chk("tx ticks from this timer", 32'(m % 2), 32'(tx_n));
    end
    serial_mode_i <= 2'h1;
    far.pulses = 0;
    rx_n = 0;
    tx_n = 0;
    t1_en <= 1'b1;
    idle(40);
    t1_en <= 1'b0;
    idle(5);
    chk("rx ticks from other timer", 32'(far.pulses), 32'(rx_n));
    chk("tx ticks from other timer", 32'(far.pulses), 32'(tx_n));
    $display("test baud done");
    wb(1'b1, tmc_pkg::OFF_COUNT, 32'h0055);
    far.drop(1'b1);
    idle(10);
    rd(tmc_pkg::OFF_CTRL, 32'h0, "trigger ignored");
    wb(1'b1, tmc_pkg::OFF_CTRL, 32'h09);
    far.drop(1'b1);
    idle(10);
    rd(tmc_pkg::OFF_CTRL, 32'h49, "external flag set");
    rd(tmc_pkg::OFF_RELOAD, 32'h0055, "captured count");
    rd(tmc_pkg::OFF_IRQ_STAT, 32'h3, "status external");
    wb(1'b1, tmc_pkg::OFF_MODE, 32'h4);
    idle(3);
    chk("timer request", 32'h1, 32'(timer_req_o));
    wb(1'b1, tmc_pkg::OFF_MODE, 32'h5);
    idle(3);
    chk("no request in up/down mode", 32'h0, 32'(timer_req_o));
    wb(1'b1, tmc_pkg::OFF_IRQ_STAT, 32'h2);
    wb(1'b1, tmc_pkg::OFF_CTRL, 32'h19);
    far.drop(1'b1);
    idle(10);
    rd(tmc_pkg::OFF_CTRL, 32'h19, "no trigger while baud source");
    $display("test trigger done");
    wb(1'b1, tmc_pkg::OFF_COUNT, 32'h0);
    wb(1'b1, tmc_pkg::OFF_CTRL, 32'h06);
    repeat (3) far.drop(1'b0);
    idle(10);
    wb(1'b1, tmc_pkg::OFF_CTRL, 32'h00);
    rd(tmc_pkg::OFF_COUNT, 32'h3, "counted pin edges");
    $display("test counter done");
    conclude();
  end
endmodule

// ### hw/tmc_fall_sync.sv
// Purpose: Brings an asynchronous pin into the clock domain and flags its falling edges.
// Assumes: The pin idles high.
// Notes: A change counts once the second and third stages agree.
module tmc_fall_sync (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic fall_o
);
  logic meta;
  logic sync2;
  logic sync3;
  logic stable;
  wire agree = (sync2 == sync3);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
      stable <= 1'b1;
      fall_o <= 1'b0;
    end else begin
      meta <= pin_i;
      sync2 <= meta;
      sync3 <= sync2;
      if (agree) begin
        stable <= sync3;
      end
      fall_o <= agree & ~sync3 & stable;
    end
  end
endmodule

// ### hw/tmc_pkg.sv
// Purpose: Shared constants and types of the third-timer control block.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus, one register per word.
// Notes: Every offset, field position, reset value and divider count lives here once.
package tmc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int COUNT_W = 16;
  localparam int PRESC_W = 4;

  localparam logic [7:0] OFF_CTRL = 8'hc8;
  localparam logic [7:0] OFF_MODE = 8'hcc;
  localparam logic [7:0] OFF_COUNT = 8'hd0;
  localparam logic [7:0] OFF_RELOAD = 8'hd4;
  localparam logic [7:0] OFF_IRQ_STAT = 8'hd8;
  localparam logic [7:0] OFF_IRQ_MASK = 8'hdc;

  localparam int CTL_CP_BIT = 0;
  localparam int CTL_CT_BIT = 1;
  localparam int CTL_RUN_BIT = 2;
  localparam int CTL_EXTEN_BIT = 3;
  localparam int CTL_TXSEL_BIT = 4;
  localparam int CTL_RXSEL_BIT = 5;
  localparam int CTL_EXTF_BIT = 6;
  localparam int CTL_OVF_BIT = 7;

  localparam int MODE_DOWN_COUNT_ENABLE_BIT = 0;
  localparam int MODE_SIXCLK_BIT = 1;
  localparam int MODE_TIE_BIT = 2;
  localparam int MODE_W = 3;

  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_EXT_BIT = 1;
  localparam int IRQ_W = 2;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  localparam logic [3:0] DIV_SIX_CLOCK = 4'h6;
  localparam logic [3:0] DIV_TWELVE_CLOCK = 4'hc;

  localparam logic [1:0] SER_MODE_1 = 2'h1;
  localparam logic [1:0] SER_MODE_3 = 2'h3;

  typedef enum logic [1:0] {
    TMC_BUS_IDLE = 2'b00,
    TMC_BUS_ACK = 2'b01
  } tmc_bus_state_t;
endpackage

// ### hw/tmc_prescaler.sv
// Purpose: Divides the core clock into a one-cycle increment enable.
// Assumes: The core clock stands for the oscillator.
// Notes: The divider restarts whenever it is disabled.
module tmc_prescaler #(
  parameter int CNT_W = tmc_pkg::PRESC_W
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic six_clock_i,
  output logic tick_o
);
  logic [CNT_W-1:0] count;
  wire [CNT_W-1:0] last = six_clock_i ? CNT_W'(tmc_pkg::DIV_SIX_CLOCK - 4'h1)
                                      : CNT_W'(tmc_pkg::DIV_TWELVE_CLOCK - 4'h1);
  wire wrap = (count >= last);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= '0;
      tick_o <= 1'b0;
    end else begin
      count <= (!enable_i || wrap) ? '0 : count + CNT_W'(1);
      tick_o <= enable_i & wrap;
    end
  end
endmodule

// ### hw/tmc_top.sv
// Purpose: Control and status logic of the third 16-bit timer/counter with a Wishbone register slave.
// Assumes: Classic Wishbone, 32-bit data, byte addresses; pins are asynchronous to mclk_i.
// Notes: Up counting only; the down-count bit only gates the external-flag interrupt request.
module tmc_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [tmc_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [tmc_pkg::DATA_W-1:0] dat_i,
  output logic [tmc_pkg::DATA_W-1:0] dat_o,
  output logic ack_o,
  input wire logic count_pin_i,
  input wire logic trigger_pin_i,
  input wire logic [1:0] serial_mode_i,
  input wire logic t1_overflow_i,
  output logic rx_baud_tick_o,
  output logic tx_baud_tick_o,
  output logic timer_req_o,
  output logic irq_o
);
  tmc_pkg::tmc_bus_state_t state;
  logic [7:0] ctrl;
  logic [tmc_pkg::MODE_W-1:0] mode;
  logic [tmc_pkg::COUNT_W-1:0] count;
  logic [tmc_pkg::COUNT_W-1:0] reload_capture;
  logic [tmc_pkg::IRQ_W-1:0] irq_stat;
  logic [tmc_pkg::IRQ_W-1:0] irq_mask;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  function automatic logic uses_timer_baud(input logic [1:0] smode);
    uses_timer_baud = (smode == tmc_pkg::SER_MODE_1) || (smode == tmc_pkg::SER_MODE_3);
  endfunction

  // Bus decode. Writes land at the edge where the master sees ack high.
  wire bus_req = cyc_i & stb_i;
  wire wr_now = bus_req & we_i & ack_o;
  wire wr_lo = wr_now & sel_i[0];
  wire wr_hi = wr_now & sel_i[1];
  wire hit_ctrl = hit(adr_i, tmc_pkg::OFF_CTRL);
  wire hit_mode = hit(adr_i, tmc_pkg::OFF_MODE);
  wire hit_count = hit(adr_i, tmc_pkg::OFF_COUNT);
  wire hit_reload = hit(adr_i, tmc_pkg::OFF_RELOAD);
  wire hit_stat = hit(adr_i, tmc_pkg::OFF_IRQ_STAT);
  wire hit_mask = hit(adr_i, tmc_pkg::OFF_IRQ_MASK);
  wire ctrl_wr = wr_lo & hit_ctrl;
  wire mode_wr = wr_lo & hit_mode;
  wire count_wr_lo = wr_lo & hit_count;
  wire count_wr_hi = wr_hi & hit_count;
  wire reload_wr_lo = wr_lo & hit_reload;
  wire reload_wr_hi = wr_hi & hit_reload;
  wire stat_wr = wr_lo & hit_stat;
  wire mask_wr = wr_lo & hit_mask;

  // Control fields.
  wire cap_sel = ctrl[tmc_pkg::CTL_CP_BIT];
  wire ct_sel = ctrl[tmc_pkg::CTL_CT_BIT];
  wire run = ctrl[tmc_pkg::CTL_RUN_BIT];
  wire ext_en = ctrl[tmc_pkg::CTL_EXTEN_BIT];
  wire tx_sel = ctrl[tmc_pkg::CTL_TXSEL_BIT];
  wire rx_sel = ctrl[tmc_pkg::CTL_RXSEL_BIT];
  wire ext_flag = ctrl[tmc_pkg::CTL_EXTF_BIT];
  wire ovf_flag = ctrl[tmc_pkg::CTL_OVF_BIT];
  wire down_count_enable = mode[tmc_pkg::MODE_DOWN_COUNT_ENABLE_BIT];
  wire six_clock = mode[tmc_pkg::MODE_SIXCLK_BIT];
  wire timer_ie = mode[tmc_pkg::MODE_TIE_BIT];
  wire baud_any = rx_sel | tx_sel;

  // Increment sources.
  logic presc_tick;
  logic count_fall;
  logic trig_fall;

  tmc_prescaler #(
    .CNT_W(tmc_pkg::PRESC_W)
  ) u_presc (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .enable_i(run & ~ct_sel),
    .six_clock_i(six_clock),
    .tick_o(presc_tick)
  );

  tmc_fall_sync u_count_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .pin_i(count_pin_i),
    .fall_o(count_fall)
  );

  tmc_fall_sync u_trig_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .pin_i(trigger_pin_i),
    .fall_o(trig_fall)
  );

  wire step = run & (ct_sel ? count_fall : presc_tick);
  wire ovf_event = step & (count == tmc_pkg::COUNT_MAX);
  wire reload_mode = ~cap_sel | baud_any;
  wire trig_event = trig_fall & ext_en & ~baud_any;
  wire do_capture = trig_event & ~reload_mode;
  wire do_reload = (ovf_event & reload_mode) | (trig_event & reload_mode);
  wire set_ovf = ovf_event & ~baud_any;
  wire set_ext = trig_event;

  // Flags: a hardware set wins over a software write in the same cycle.
  wire [7:0] ctrl_wval = dat_i[7:0];
  wire next_ovf = set_ovf | (ctrl_wr ? ctrl_wval[tmc_pkg::CTL_OVF_BIT] : ovf_flag);
  wire next_ext = set_ext | (ctrl_wr ? ctrl_wval[tmc_pkg::CTL_EXTF_BIT] : ext_flag);
  wire [5:0] next_low = ctrl_wr ? ctrl_wval[5:0] : ctrl[5:0];

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= tmc_pkg::CTRL_RESET;
      mode <= tmc_pkg::MODE_RESET;
    end else begin
      ctrl <= {next_ovf, next_ext, next_low};
      if (mode_wr) begin
        mode <= dat_i[tmc_pkg::MODE_W-1:0];
      end
    end
  end

  // Counter. A software write beats counting in the same cycle.
  wire [15:0] count_inc = count + 16'h0001;
  wire [15:0] count_hw = do_reload ? reload_capture : (step ? count_inc : count);
  wire [15:0] next_count = {count_wr_hi ? dat_i[15:8] : count_hw[15:8],
                            count_wr_lo ? dat_i[7:0] : count_hw[7:0]};

  // Capture register. A capture wins over a software write.
  wire [15:0] next_reload = do_capture ? count :
                            {reload_wr_hi ? dat_i[15:8] : reload_capture[15:8],
                             reload_wr_lo ? dat_i[7:0] : reload_capture[7:0]};

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= tmc_pkg::COUNT_RESET;
      reload_capture <= tmc_pkg::RELOAD_RESET;
    end else begin
      count <= next_count;
      reload_capture <= next_reload;
    end
  end

  // Sticky event status, cleared by writing ones; new events win.
  wire [1:0] irq_events = {set_ext, ovf_event};
  wire [1:0] stat_clear = stat_wr ? dat_i[1:0] : 2'h0;
  wire [1:0] next_stat = irq_events | (irq_stat & ~stat_clear);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat <= tmc_pkg::IRQ_RESET;
      irq_mask <= tmc_pkg::IRQ_RESET;
      irq_o <= 1'b0;
    end else begin
      irq_stat <= next_stat;
      if (mask_wr) begin
        irq_mask <= dat_i[1:0];
      end
      irq_o <= |(next_stat & (mask_wr ? dat_i[1:0] : irq_mask));
    end
  end

  // Timer interrupt request and serial baud selection.
  wire ext_req = ext_flag & ~down_count_enable;
  wire rx_use = rx_sel & uses_timer_baud(serial_mode_i);
  wire tx_use = tx_sel & uses_timer_baud(serial_mode_i);
  wire next_rx_tick = rx_sel ? (rx_use & ovf_event) : t1_overflow_i;
  wire next_tx_tick = tx_sel ? (tx_use & ovf_event) : t1_overflow_i;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_req_o <= 1'b0;
      rx_baud_tick_o <= 1'b0;
      tx_baud_tick_o <= 1'b0;
    end else begin
      timer_req_o <= timer_ie & (ovf_flag | ext_req);
      rx_baud_tick_o <= next_rx_tick;
      tx_baud_tick_o <= next_tx_tick;
    end
  end

  // Wishbone slave: one wait state, ack for one cycle, unmapped reads return zero.
  wire [31:0] rd_mux = hit_ctrl ? {24'h0, ctrl} :
                       hit_mode ? {29'h0, mode} :
                       hit_count ? {16'h0, count} :
                       hit_reload ? {16'h0, reload_capture} :
                       hit_stat ? {30'h0, irq_stat} :
                       hit_mask ? {30'h0, irq_mask} : 32'h0;

  assign ack_o = (state == tmc_pkg::TMC_BUS_ACK);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= tmc_pkg::TMC_BUS_IDLE;
      dat_o <= 32'h0;
    end else begin
      case (state)
        tmc_pkg::TMC_BUS_IDLE: begin
          if (bus_req) begin
            state <= tmc_pkg::TMC_BUS_ACK;
            dat_o <= we_i ? 32'h0 : rd_mux;
          end
        end
        tmc_pkg::TMC_BUS_ACK: begin
          state <= tmc_pkg::TMC_BUS_IDLE;
        end
        default: begin
          state <= tmc_pkg::TMC_BUS_IDLE;
        end
      endcase
    end
  end

  // Checks.
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_presc_quiet;
    !presc_tick [*5];
  endsequence

  sequence s_count_step;
    run && ct_sel && count_fall && count != tmc_pkg::COUNT_MAX && !trig_event && !count_wr_lo && !count_wr_hi;
  endsequence

  property p_ovf_sets;
    set_ovf |=> ovf_flag;
  endproperty
  a_ovf_sets: assert property (p_ovf_sets) else $error("overflow flag not set after overflow");

  property p_ovf_holds;
    ovf_flag && !ctrl_wr |=> ovf_flag;
  endproperty
  a_ovf_holds: assert property (p_ovf_holds) else $error("overflow flag dropped without a write");

  property p_ovf_baud;
    ovf_event && baud_any && !ovf_flag && !ctrl_wr |=> !ovf_flag;
  endproperty
  a_ovf_baud: assert property (p_ovf_baud) else $error("overflow flag set while clocking serial port");

  property p_ext_sets;
    trig_fall && ext_en && !baud_any |=> ext_flag;
  endproperty
  a_ext_sets: assert property (p_ext_sets) else $error("external flag not set on trigger edge");

  property p_req_ext;
    ext_flag && timer_ie && !down_count_enable |=> timer_req_o;
  endproperty
  a_req_ext: assert property (p_req_ext) else $error("no timer request from external flag");

  property p_no_req_down_count_enable;
    ext_flag && !ovf_flag && down_count_enable |=> !timer_req_o;
  endproperty
  a_no_req_down_count_enable: assert property (p_no_req_down_count_enable) else $error("external flag requested in up/down mode");

  property p_rx_timer;
    rx_sel && uses_timer_baud(serial_mode_i) && ovf_event |=> rx_baud_tick_o;
  endproperty
  a_rx_timer: assert property (p_rx_timer) else $error("receive baud tick missing on overflow");

  property p_tx_timer1;
    !tx_sel && t1_overflow_i |=> tx_baud_tick_o;
  endproperty
  a_tx_timer1: assert property (p_tx_timer1) else $error("transmit baud tick missing from timer 1");

  property p_trig_ignored;
    !ext_en && !reload_wr_lo && !reload_wr_hi |=> $stable(reload_capture);
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("capture register changed with trigger disabled");

  property p_stop_holds;
    !run && !trig_event && !count_wr_lo && !count_wr_hi |=> $stable(count);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("count moved while stopped");

  property p_presc_spacing;
    presc_tick |=> s_presc_quiet;
  endproperty
  a_presc_spacing: assert property (p_presc_spacing) else $error("prescaler ticks closer than six clocks");

  property p_pin_count;
    s_count_step |=> count == $past(count) + 16'h0001;
  endproperty
  a_pin_count: assert property (p_pin_count) else $error("count did not step on pin edge");

  property p_baud_reload;
    ovf_event && baud_any && !count_wr_lo && !count_wr_hi |=> count == $past(reload_capture);
  endproperty
  a_baud_reload: assert property (p_baud_reload) else $error("no forced reload while clocking serial port");
endmodule
